// ### rtl/ptd_defs.svh
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH

// register byte offsets
`define PTD_OFF_CTRL    8'h00
`define PTD_OFF_LINK    8'h04
`define PTD_OFF_STAT    8'h08
`define PTD_OFF_CNT     8'h0c
`define PTD_OFF_CMP0    8'h10
`define PTD_OFF_CMP5    8'h24
`define PTD_OFF_PRD     8'h28
`define PTD_OFF_PRDB    8'h2c
`define PTD_OFF_PRDDB   8'h30
`define PTD_OFF_ADA     8'h34
`define PTD_OFF_ADAB    8'h38
`define PTD_OFF_ADADB   8'h3c
`define PTD_OFF_ADB     8'h40
`define PTD_OFF_ADBB    8'h44
`define PTD_OFF_ADBDB   8'h48
`define PTD_OFF_NEG     8'h4c
`define PTD_OFF_DTC     8'h50
`define PTD_OFF_SOS     8'h54
`define PTD_OFF_DVU     8'h58
`define PTD_OFF_DVD     8'h5c
`define PTD_OFF_DBU     8'h60
`define PTD_OFF_DBD     8'h64
`define PTD_OFF_ISTS    8'h68
`define PTD_OFF_ICLR    8'h6c
`define PTD_OFF_IEN     8'h70

// control register fields
`define PTD_CTRL_RUN    0
`define PTD_CTRL_PBUF   1
`define PTD_CTRL_PDBL   2
`define PTD_CTRL_ABUF   3
`define PTD_CTRL_ADBUF  4
`define PTD_CTRL_ADDBL  5
`define PTD_CTRL_W      6

// skip link control fields
`define PTD_LNK_D       0
`define PTD_LNK_E       1
`define PTD_LNK_F       2
`define PTD_LNK_ADA     6
`define PTD_LNK_ADB     7
`define PTD_SKSEL_LSB   8
`define PTD_SKCNT_LSB   12
`define PTD_SKIP_OFF    2'h0

// status, negate, dead time fields
`define PTD_STS_DIR     15
`define PTD_NEG_SWN     0
`define PTD_NEG_NEA     1
`define PTD_NEG_NEB     2
`define PTD_NFS_LSB     4
`define PTD_NFS_CMP1    4'h1
`define PTD_NFS_CMP2    4'h4
`define PTD_NFS_CMP3    4'h5
`define PTD_NFS_EXT     4'h7
`define PTD_NFS_SW      3
`define PTD_DT_TDE      0
`define PTD_DT_UBUF     4
`define PTD_DT_DBUF     5
`define PTD_DT_COPY     8

// protection codes
`define PTD_SOS_OK      2'h0
`define PTD_SOS_ZERO    2'h1
`define PTD_SOS_TRGH    2'h2
`define PTD_SOS_PEAK    2'h3

// reset value of period, compare and timing registers
`define PTD_RST_FULL    32'hffffffff

// interrupt event bits
`define PTD_EV_OVF      0
`define PTD_EV_UDF      1
`define PTD_EV_CMA      2
`define PTD_EV_CMB      3
`define PTD_EV_CMD      4
`define PTD_EV_CME      5
`define PTD_EV_CMF      6
`define PTD_EV_ADA      7
`define PTD_EV_ADB      8
`define PTD_EV_PROT     9
`define PTD_EV_W        10

`endif

// ### rtl/ptd_pkg.sv
package ptd_pkg;
	typedef struct packed {
		logic [31:0] up;
		logic [31:0] down;
	} ptd_dt_pair_t;

	typedef struct packed {
		logic [31:0] timing;
		logic [31:0] buffer;
		logic [31:0] dbuffer;
	} ptd_adc_t;
endpackage

// ### rtl/ptd_timer.sv
`timescale 1ns/100ps
`include "ptd_defs.svh"

module ptd_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comparator_one,
	input  wire logic        comparator_two,
	input  wire logic        comparator_three,
	input  wire logic        external_trigger_pin,
	output logic             pwm_out_a,
	output logic             pwm_out_b,
	output logic             adc_start_a,
	output logic             adc_start_b,
	output logic             irq
);
	logic [`PTD_CTRL_W-1:0]  ctrl_r;
	logic [15:0]             link_r;
	logic [15:0]             neg_r;
	logic [15:0]             dtc_r;
	logic [31:0]             cnt_r;
	logic                    dir_r;
	logic [31:0]             cmp_r [6];
	logic [31:0]             prd_r;
	logic [31:0]             prdb_r;
	logic [31:0]             prddb_r;
	ptd_pkg::ptd_adc_t       ada_r;
	ptd_pkg::ptd_adc_t       adb_r;
	ptd_pkg::ptd_dt_pair_t   dv_r;
	ptd_pkg::ptd_dt_pair_t   db_r;
	logic [2:0]              skip_cnt_r;
	logic [1:0]              sos_r;
	logic [`PTD_EV_W-1:0]    ists_r;
	logic [`PTD_EV_W-1:0]    ien_r;
	logic [3:0]              sync1_r;
	logic [3:0]              sync2_r;
	logic [31:0]             prdata_r;
	logic                    pwm_a_r;
	logic                    pwm_b_r;
	logic                    ada_r_o;
	logic                    adb_r_o;
	logic                    wr;
	logic                    hit;
	logic [31:0]             rd_data;
	logic [2:0]              cmp_idx;
	logic                    cmp_hit;
	logic                    run;
	logic                    peak;
	logic                    trough;
	logic                    xfer;
	logic                    skip_on;
	logic                    skip_hit;
	logic                    lpass;
	logic [31:0]             a_new;
	logic [1:0]              sos_nxt;
	logic [`PTD_EV_W-1:0]    ev;
	logic                    neg_act;
	logic [31:0]             cmpb_nxt;

	function automatic logic at(input logic [7:0] a, input logic [7:0] o);
		at = (a == o);
	endfunction

	// decode of the negate source field
	function automatic logic neg_src(input logic [3:0] negate_source_select,
	                                 input logic [3:0] s,
	                                 input logic sw);
		if (negate_source_select[`PTD_NFS_SW]) begin
			neg_src = sw;
		end else if (negate_source_select == `PTD_NFS_CMP1) begin
			neg_src = s[0];
		end else if (negate_source_select == `PTD_NFS_CMP2) begin
			neg_src = s[1];
		end else if (negate_source_select == `PTD_NFS_CMP3) begin
			neg_src = s[2];
		end else if (negate_source_select == `PTD_NFS_EXT) begin
			neg_src = s[3];
		end else begin
			neg_src = 1'b0;
		end
	endfunction

	assign wr      = psel & penable & pwrite & ce;
	assign cmp_hit = (paddr >= `PTD_OFF_CMP0) && (paddr <= `PTD_OFF_CMP5)
	                 && (paddr[1:0] == 2'h0);
	assign cmp_idx = 3'((paddr - `PTD_OFF_CMP0) >> 2);
	assign hit     = cmp_hit || (paddr[1:0] == 2'h0 &&
	                 (paddr <= `PTD_OFF_CNT ||
	                 (paddr >= `PTD_OFF_PRD && paddr <= `PTD_OFF_IEN)));
	assign pready  = ce;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = prdata_r;

	always_comb begin
		rd_data = 32'h0;
		if (cmp_hit) begin
			rd_data = cmp_r[cmp_idx];
		end else begin
			unique case (paddr)
				`PTD_OFF_CTRL:  rd_data = 32'(ctrl_r);
				`PTD_OFF_LINK:  rd_data = 32'(link_r);
				`PTD_OFF_STAT:  rd_data = 32'({dir_r, 12'h0, skip_cnt_r});
				`PTD_OFF_CNT:   rd_data = cnt_r;
				`PTD_OFF_PRD:   rd_data = prd_r;
				`PTD_OFF_PRDB:  rd_data = prdb_r;
				`PTD_OFF_PRDDB: rd_data = prddb_r;
				`PTD_OFF_ADA:   rd_data = ada_r.timing;
				`PTD_OFF_ADAB:  rd_data = ada_r.buffer;
				`PTD_OFF_ADADB: rd_data = ada_r.dbuffer;
				`PTD_OFF_ADB:   rd_data = adb_r.timing;
				`PTD_OFF_ADBB:  rd_data = adb_r.buffer;
				`PTD_OFF_ADBDB: rd_data = adb_r.dbuffer;
				`PTD_OFF_NEG:   rd_data = 32'(neg_r);
				`PTD_OFF_DTC:   rd_data = 32'(dtc_r);
				`PTD_OFF_SOS:   rd_data = 32'(sos_r);
				`PTD_OFF_DVU:   rd_data = dv_r.up;
				`PTD_OFF_DVD:   rd_data = dv_r.down;
				`PTD_OFF_DBU:   rd_data = db_r.up;
				`PTD_OFF_DBD:   rd_data = db_r.down;
				`PTD_OFF_ISTS:  rd_data = 32'(ists_r);
				`PTD_OFF_IEN:   rd_data = 32'(ien_r);
				default:        rd_data = 32'h0;
			endcase
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata_r <= rd_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
			link_r <= 16'h0;
			neg_r  <= 16'h0;
			dtc_r  <= 16'h0;
			ien_r  <= '0;
		end else if (wr) begin
			if (at(paddr, `PTD_OFF_CTRL))
				ctrl_r <= pwdata[`PTD_CTRL_W-1:0];
			if (at(paddr, `PTD_OFF_LINK))
				link_r <= pwdata[15:0];
			if (at(paddr, `PTD_OFF_NEG))
				neg_r <= pwdata[15:0];
			if (at(paddr, `PTD_OFF_DTC))
				dtc_r <= pwdata[15:0];
			if (at(paddr, `PTD_OFF_IEN))
				ien_r <= pwdata[`PTD_EV_W-1:0];
		end
	end

	assign run    = ctrl_r[`PTD_CTRL_RUN];
	assign peak   = run & dir_r & (cnt_r >= prd_r);
	assign trough = run & ~dir_r & (cnt_r == 32'h0);
	assign xfer   = peak | trough;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
			dir_r <= 1'b1;
		end else if (ce) begin
			if (wr && at(paddr, `PTD_OFF_CNT)) begin
				cnt_r <= pwdata;
			end else if (peak) begin
				dir_r <= 1'b0;
				cnt_r <= cnt_r - 32'h1;
			end else if (trough) begin
				dir_r <= 1'b1;
				cnt_r <= cnt_r + 32'h1;
			end else if (run) begin
				cnt_r <= dir_r ? cnt_r + 32'h1 : cnt_r - 32'h1;
			end
		end
	end

	// period with single or double buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prd_r   <= `PTD_RST_FULL;
			prdb_r  <= `PTD_RST_FULL;
			prddb_r <= `PTD_RST_FULL;
		end else if (ce) begin
			if (wr && at(paddr, `PTD_OFF_PRD))
				prd_r <= pwdata;
			if (wr && at(paddr, `PTD_OFF_PRDB))
				prdb_r <= pwdata;
			if (wr && at(paddr, `PTD_OFF_PRDDB))
				prddb_r <= pwdata;
			if (xfer && ctrl_r[`PTD_CTRL_PBUF])
				prd_r <= prdb_r;
			if (xfer && ctrl_r[`PTD_CTRL_PDBL])
				prdb_r <= prddb_r;
		end
	end

	assign a_new    = ctrl_r[`PTD_CTRL_ABUF] ? cmp_r[2] : cmp_r[0];
	assign cmpb_nxt = dir_r ? cmp_r[0] + dv_r.up : cmp_r[0] - dv_r.down;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 6; i++)
				cmp_r[i] <= `PTD_RST_FULL;
		end else if (ce) begin
			if (wr && cmp_hit)
				cmp_r[cmp_idx] <= pwdata;
			if (xfer && ctrl_r[`PTD_CTRL_ABUF])
				cmp_r[0] <= cmp_r[2];
			if (dtc_r[`PTD_DT_TDE])
				cmp_r[1] <= cmpb_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ada_r <= '1;
			adb_r <= '1;
		end else if (ce) begin
			if (wr && at(paddr, `PTD_OFF_ADA))   ada_r.timing  <= pwdata;
			if (wr && at(paddr, `PTD_OFF_ADAB))  ada_r.buffer  <= pwdata;
			if (wr && at(paddr, `PTD_OFF_ADADB)) ada_r.dbuffer <= pwdata;
			if (wr && at(paddr, `PTD_OFF_ADB))   adb_r.timing  <= pwdata;
			if (wr && at(paddr, `PTD_OFF_ADBB))  adb_r.buffer  <= pwdata;
			if (wr && at(paddr, `PTD_OFF_ADBDB)) adb_r.dbuffer <= pwdata;
			if (xfer && ctrl_r[`PTD_CTRL_ADBUF]) begin
				ada_r.timing <= ada_r.buffer;
				adb_r.timing <= adb_r.buffer;
			end
			if (xfer && ctrl_r[`PTD_CTRL_ADDBL]) begin
				ada_r.buffer <= ada_r.dbuffer;
				adb_r.buffer <= adb_r.dbuffer;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dv_r <= '0;
			db_r <= '0;
		end else if (ce) begin
			if (wr && at(paddr, `PTD_OFF_DVD))
				dv_r.down <= pwdata;
			if (wr && at(paddr, `PTD_OFF_DBD))
				db_r.down <= pwdata;
			if (wr && at(paddr, `PTD_OFF_DVU)) begin
				dv_r.up <= pwdata;
				if (dtc_r[`PTD_DT_COPY])
					dv_r.down <= pwdata;
			end
			if (wr && at(paddr, `PTD_OFF_DBU)) begin
				db_r.up <= pwdata;
				if (dtc_r[`PTD_DT_COPY])
					db_r.down <= pwdata;
			end
			if (xfer && dtc_r[`PTD_DT_UBUF])
				dv_r.up <= db_r.up;
			if (xfer && dtc_r[`PTD_DT_DBUF])
				dv_r.down <= db_r.down;
		end
	end

	assign skip_on  = link_r[`PTD_SKSEL_LSB+:2] != `PTD_SKIP_OFF;
	assign skip_hit = skip_cnt_r == link_r[`PTD_SKCNT_LSB+:3];
	assign lpass    = ~skip_on | (skip_cnt_r == 3'h0);

	// count skipped peak and trough events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_cnt_r <= 3'h0;
		end else if (ce) begin
			if (!skip_on)
				skip_cnt_r <= 3'h0;
			else if (xfer)
				skip_cnt_r <= skip_hit ? 3'h0 : skip_cnt_r + 3'h1;
		end
	end

	always_comb begin
		sos_nxt = `PTD_SOS_OK;
		if (a_new == 32'h0)
			sos_nxt = `PTD_SOS_ZERO;
		else if (a_new >= prd_r)
			sos_nxt = peak ? `PTD_SOS_PEAK : `PTD_SOS_TRGH;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sos_r <= `PTD_SOS_OK;
		end else if (ce && xfer) begin
			sos_r <= sos_nxt;
		end
	end

	always_comb begin
		ev = '0;
		ev[`PTD_EV_OVF]  = peak & (~skip_on | skip_hit);
		ev[`PTD_EV_UDF]  = trough & (~skip_on | skip_hit);
		ev[`PTD_EV_CMA]  = run & (cnt_r == cmp_r[0]);
		ev[`PTD_EV_CMB]  = run & (cnt_r == cmp_r[1]);
		// compare D to F gated when linked
		ev[`PTD_EV_CMD]  = run & (cnt_r == cmp_r[3]) &
		                   (~link_r[`PTD_LNK_D] | lpass);
		ev[`PTD_EV_CME]  = run & (cnt_r == cmp_r[4]) &
		                   (~link_r[`PTD_LNK_E] | lpass);
		ev[`PTD_EV_CMF]  = run & (cnt_r == cmp_r[5]) &
		                   (~link_r[`PTD_LNK_F] | lpass);
		ev[`PTD_EV_ADA]  = run & (cnt_r == ada_r.timing) &
		                   (~link_r[`PTD_LNK_ADA] | lpass);
		ev[`PTD_EV_ADB]  = run & (cnt_r == adb_r.timing) &
		                   (~link_r[`PTD_LNK_ADB] | lpass);
		ev[`PTD_EV_PROT] = xfer & (sos_nxt != `PTD_SOS_OK);
	end

	// sticky status, set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ists_r <= '0;
		end else if (ce) begin
			if (wr && at(paddr, `PTD_OFF_ICLR))
				ists_r <= (ists_r & ~pwdata[`PTD_EV_W-1:0]) | ev;
			else
				ists_r <= ists_r | ev;
		end
	end

	assign irq = |(ists_r & ien_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else if (ce) begin
			sync1_r <= {external_trigger_pin, comparator_three,
			            comparator_two, comparator_one};
			sync2_r <= sync1_r;
		end
	end

	assign neg_act = neg_src(neg_r[`PTD_NFS_LSB+:4], sync2_r,
	                         neg_r[`PTD_NEG_SWN]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_a_r <= 1'b0;
			pwm_b_r <= 1'b0;
			ada_r_o <= 1'b0;
			adb_r_o <= 1'b0;
		end else if (ce) begin
			pwm_a_r <= (sos_r == `PTD_SOS_OK) & (cnt_r < cmp_r[0]) &
			           ~(neg_act & neg_r[`PTD_NEG_NEA]);
			pwm_b_r <= (sos_r == `PTD_SOS_OK) & (cnt_r >= cmp_r[1]) &
			           ~(neg_act & neg_r[`PTD_NEG_NEB]);
			ada_r_o <= ev[`PTD_EV_ADA];
			adb_r_o <= ev[`PTD_EV_ADB];
		end
	end

	assign pwm_out_a   = pwm_a_r;
	assign pwm_out_b   = pwm_b_r;
	assign adc_start_a = ada_r_o;
	assign adc_start_b = adb_r_o;

	chk_link_d_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && run && cnt_r == cmp_r[3] && link_r[`PTD_LNK_D] && skip_on
		&& skip_cnt_r != 3'h0 && !ists_r[`PTD_EV_CMD]
		|=> !ists_r[`PTD_EV_CMD])
		else $error("linked compare D not skipped");

	chk_skip_wrap: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && skip_on && xfer && skip_hit |=> skip_cnt_r == 3'h0)
		else $error("skip counter did not wrap");

	chk_skip_step: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && skip_on && xfer && !skip_hit && !wr
		|=> skip_cnt_r == $past(skip_cnt_r) + 3'h1)
		else $error("skip counter did not advance");

	chk_adc_link: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && run && cnt_r == ada_r.timing && link_r[`PTD_LNK_ADA]
		&& !lpass |=> !adc_start_a)
		else $error("linked A/D request not skipped");

	chk_dir_peak: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && peak && !wr |=> !dir_r ##1 (ce ? !peak : 1'b1))
		else $error("direction not down after peak");

	chk_negate_sw: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && neg_r[`PTD_NFS_LSB+3] && neg_r[`PTD_NEG_SWN]
		&& neg_r[`PTD_NEG_NEA] |=> !pwm_out_a)
		else $error("software negate did not force output low");

	chk_tde_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && dtc_r[`PTD_DT_TDE] |=> cmp_r[1] == $past(cmpb_nxt))
		else $error("compare B not loaded from dead time");

	chk_dt_xfer: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && xfer && dtc_r[`PTD_DT_UBUF] && !wr
		|=> dv_r.up == $past(db_r.up))
		else $error("up dead-time buffer not transferred");

	chk_prot_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		ce && xfer && a_new == 32'h0
		|=> sos_r == `PTD_SOS_ZERO && ists_r[`PTD_EV_PROT])
		else $error("protection zero state not reported");
endmodule

// ### verif/ptd_stage_model.sv
`timescale 1ns/100ps

module ptd_stage_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        gate_a,
	input  wire logic        gate_b,
	output logic      [15:0] on_a,
	output logic      [15:0] on_b
);
	// conduction time of each switch, read by the bench
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_a <= 16'h0000;
			on_b <= 16'h0000;
		end else begin
			on_a <= on_a + {15'h0000, gate_a};
			on_b <= on_b + {15'h0000, gate_b};
		end
	end
endmodule

// ### verif/tb_pwm_timer_deadtime_skip_negate.sv
`timescale 1ns/100ps
`include "ptd_defs.svh"

module tb_pwm_timer_deadtime_skip_negate;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  neg_in;
	logic        pwm_a;
	logic        pwm_b;
	logic        irq;
	logic [15:0] on_a;
	logic [15:0] on_b;
	logic [15:0] sa;
	logic [15:0] sb;
	logic [31:0] v;
	logic        err;
	logic [3:0]  seen;
	logic        ada_o;
	logic        adb_o;
	logic [31:0] pa;
	logic [31:0] pb;
	int          failures;
	int          check_count;
	int          cyc;
	int          k;
	logic [7:0]  lw [20] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44,
		8'h48, 8'h58, 8'h5c, 8'h60, 8'h64};
	logic [7:0]  ncode [5] = '{8'h87, 8'h12, 8'h42, 8'h52, 8'h72};

	ptd_timer uut (
		.pclk                 (pclk),
		.presetn              (presetn),
		.ce                   (1'b1),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.comparator_one       (neg_in[0]),
		.comparator_two       (neg_in[1]),
		.comparator_three     (neg_in[2]),
		.external_trigger_pin (neg_in[3]),
		.pwm_out_a            (pwm_a),
		.pwm_out_b            (pwm_b),
		.adc_start_a          (ada_o),
		.adc_start_b          (adb_o),
		.irq                  (irq)
	);

	ptd_stage_model stage (
		.clk    (pclk),
		.rst_n  (presetn),
		.gate_a (pwm_a),
		.gate_b (pwm_b),
		.on_a   (on_a),
		.on_b   (on_b)
	);

	always #4 pclk = ~pclk;

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the cycle ceiling ends a stalled access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		v = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic idle(int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic poll(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		int n;
		n = 0;
		do begin
			rd(a);
			n++;
		end while ((v & m) !== e && n < 40);
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		neg_in = 4'h0;
		failures = 0;
		check_count = 0;
		cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`PTD_OFF_CNT);
		chk("counter reset", v, 32'h0);
		rd(`PTD_OFF_PRD);
		chk("period reset", v, 32'hffffffff);
		rd(`PTD_OFF_STAT);
		chk("status reset", v, 32'h00008000);
		rd(`PTD_OFF_SOS);
		chk("protection reset", v, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 20; i++)
			wr(lw[i], {lw[i], 8'ha5, ~lw[i], 8'h3c});
		for (int i = 0; i < 20; i++) begin
			rd(lw[i]);
			chk("longword", v, {lw[i], 8'ha5, ~lw[i], 8'h3c});
		end
		wr(`PTD_OFF_LINK, 32'h73c7);
		rd(`PTD_OFF_LINK);
		chk("link fields", v, 32'h73c7);
		rd(8'hfc);
		chk("unmapped error", 32'(err), 32'h1);
		chk("unmapped data", v, 32'h0);
		$display("register test done");
		wr(`PTD_OFF_DTC, 32'h100);
		wr(`PTD_OFF_DVU, 32'h11);
		rd(`PTD_OFF_DVD);
		chk("copied down", v, 32'h11);
		wr(`PTD_OFF_DTC, 32'h0);
		wr(`PTD_OFF_DVU, 32'h22);
		rd(`PTD_OFF_DVD);
		chk("separate down", v, 32'h11);
		$display("copy test done");
		wr(`PTD_OFF_LINK, 32'h0);
		wr(`PTD_OFF_CNT, 32'h0);
		wr(`PTD_OFF_PRD, 32'h14);
		wr(`PTD_OFF_CMP0, 32'ha);
		wr(8'h14, 32'ha);
		wr(`PTD_OFF_ICLR, 32'h7ff);
		wr(`PTD_OFF_IEN, 32'h1);
		wr(`PTD_OFF_CTRL, 32'h1);
		k = 0;
		while (irq !== 1'b1 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		chk("irq raised", 32'(irq), 32'h1);
		wr(`PTD_OFF_CTRL, 32'h0);
		rd(`PTD_OFF_ISTS);
		chk("overflow sticky", v & 32'h1, 32'h1);
		wr(`PTD_OFF_IEN, 32'h0);
		#1 chk("irq masked", 32'(irq), 32'h0);
		wr(`PTD_OFF_IEN, 32'h1);
		#1 chk("irq unmasked", 32'(irq), 32'h1);
		wr(`PTD_OFF_ICLR, 32'h7ff);
		#1 chk("irq cleared", 32'(irq), 32'h0);
		$display("interrupt test done");
		wr(`PTD_OFF_LINK, 32'h3100);
		wr(`PTD_OFF_CTRL, 32'h1);
		seen = 4'h0;
		for (int i = 0; i < 40; i++) begin
			rd(`PTD_OFF_STAT);
			seen[v[15]] = 1'b1;
			if (v[2:0] != 3'h0)
				seen[2] = 1'b1;
			if (v[2:0] > 3'h3)
				seen[3] = 1'b1;
		end
		chk("direction and skip", 32'(seen), 32'h7);
		$display("skip test done");
		// linked events pass one half period in four
		wr(`PTD_OFF_ADA, 32'h5);
		wr(`PTD_OFF_ADB, 32'h5);
		wr(8'h1c, 32'h5);
		wr(`PTD_OFF_LINK, 32'h3141);
		wr(`PTD_OFF_ICLR, 32'h7ff);
		pa = 32'h0;
		pb = 32'h0;
		repeat (160) begin
			@(negedge pclk);
			pa = pa + 32'(ada_o);
			pb = pb + 32'(adb_o);
		end
		chk("linked a/d a", pa, 32'h2);
		chk("free a/d b", pb, 32'h8);
		rd(`PTD_OFF_ISTS);
		chk("linked compare d", v & 32'h10, 32'h10);
		$display("link test done");
		wr(`PTD_OFF_CTRL, 32'h0);
		wr(`PTD_OFF_DVU, 32'h4);
		wr(`PTD_OFF_DVD, 32'h6);
		wr(`PTD_OFF_DTC, 32'h30);
		wr(`PTD_OFF_DBU, 32'h8);
		wr(`PTD_OFF_DBD, 32'h9);
		rd(`PTD_OFF_DVU);
		chk("up held", v, 32'h4);
		rd(`PTD_OFF_DVD);
		chk("down held", v, 32'h6);
		wr(`PTD_OFF_CTRL, 32'h1);
		poll(`PTD_OFF_DVU, 32'hffffffff, 32'h8);
		chk("up moved", v, 32'h8);
		rd(`PTD_OFF_DVD);
		chk("down moved", v, 32'h9);
		wr(`PTD_OFF_DTC, 32'h0);
		wr(`PTD_OFF_DBU, 32'h33);
		wr(`PTD_OFF_DBD, 32'h44);
		idle(90);
		rd(`PTD_OFF_DVU);
		chk("up bypass", v, 32'h8);
		rd(`PTD_OFF_DVD);
		chk("down bypass", v, 32'h9);
		$display("buffer test done");
		wr(`PTD_OFF_DTC, 32'h1);
		seen = 4'h0;
		for (int i = 0; i < 20; i++) begin
			rd(8'h14);
			if (v === 32'h12)
				seen[0] = 1'b1;
			else if (v === 32'h1)
				seen[1] = 1'b1;
			else
				seen[2] = 1'b1;
		end
		chk("auto compare b", 32'(seen), 32'h3);
		wr(`PTD_OFF_DTC, 32'h0);
		wr(8'h14, 32'ha);
		$display("negative phase test done");
		wr(`PTD_OFF_CMP0, 32'h0);
		poll(`PTD_OFF_SOS, 32'h3, 32'h1);
		chk("zero compare", v, 32'h1);
		wr(`PTD_OFF_CMP0, 32'h19);
		seen = 4'h0;
		for (int i = 0; i < 30; i++) begin
			rd(`PTD_OFF_SOS);
			if (v === 32'h2)
				seen[0] = 1'b1;
			if (v === 32'h3)
				seen[1] = 1'b1;
			if (v === 32'h0)
				seen[2] = 1'b1;
		end
		chk("over period", 32'(seen), 32'h3);
		wr(`PTD_OFF_CMP0, 32'ha);
		poll(`PTD_OFF_SOS, 32'h3, 32'h0);
		chk("normal again", v, 32'h0);
		$display("protection test done");
		for (int i = 0; i < 5; i++) begin
			neg_in <= (i == 0) ? 4'h0 : 4'h1 << (i - 1);
			wr(`PTD_OFF_NEG, {24'h0, ncode[i]});
			idle(6);
			sa = on_a;
			sb = on_b;
			idle(80);
			chk("negated a", 32'(on_a != sa), 32'h0);
			if (i == 0)
				chk("negated b", 32'(on_b != sb), 32'h0);
			else
				chk("free b", 32'(on_b != sb), 32'h1);
			neg_in <= 4'h0;
			wr(`PTD_OFF_NEG, {24'h0, ncode[i] & 8'hfe});
			idle(6);
			sa = on_a;
			idle(80);
			chk("released a", 32'(on_a != sa), 32'h1);
		end
		$display("negate test done");
		report_and_stop();
	end
endmodule
